//--- hw/pmc_pkg.sv
// How it works
// - Each cycle, add that processor's outstanding coherent reads (0 to 10) to its latency total.
// - Two independent latency registers, one for each processor.
// - Count field bits 0:27 adds one per coherent read issued.
// - Latency field bits 28:63 holds the running outstanding-read total.
// - Memory access event counter, 32 bits in bits 32:63, bits 0:31 unused.
// - Hit count field bits 0:31 adds one per inter-node cache read hit.
// - Read count field bits 32:63 adds one per inter-node cache read.
// - One hit rate register counts lookups from all four processors.
// - Both cache counters sit in one 64-bit register read together.
// - Writing the hit rate register loads both fields; reading returns both.
// - Resynchronize the 16 MHz board clock; tick on each rising edge, every 7 or 8 clocks.
// - One synchronization pulse after every 256 ticks.
// - The timestamp is one 64-bit register read as two 32-bit words; the low-word read freezes the high word.
// - The 48-bit timestamp advances when the tick-driven prescaler is at maximum.
package pmc_pkg;

  // Bit numbering in the fields below is big-endian: bit 0 is the most significant.
  localparam int unsigned CNT_W = 28;
  localparam int unsigned LAT_W = 36;
  localparam int unsigned TS_W = 48;
  localparam int unsigned SYNC_TICKS = 256;

  localparam logic [2:0] REG_LAT0 = 3'h0;
  localparam logic [2:0] REG_LAT1 = 3'h1;
  localparam logic [2:0] REG_MEM = 3'h2;
  localparam logic [2:0] REG_HIT = 3'h3;
  localparam logic [2:0] REG_TS = 3'h4;
  localparam logic [2:0] REG_CNT = 3'h5;

  localparam logic [3:0] PRE_MAX = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [CNT_W-1:0] pmc_cnt_t;
  typedef logic [LAT_W-1:0] pmc_lat_t;
  typedef logic [TS_W-1:0] pmc_ts_t;
  typedef logic [31:0] pmc_w32_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pmc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmc_axi_rsp_t;

  typedef struct packed {
    pmc_axi_rsp_t rsp;
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    pmc_w32_t stage;
    pmc_w32_t snap;
    pmc_cnt_t [1:0] lat_cnt;
    pmc_lat_t [1:0] lat_sum;
    pmc_w32_t mem;
    pmc_w32_t hit;
    pmc_w32_t rdc;
    pmc_ts_t ts;
    logic [3:0] pre;
    logic [7:0] tcnt;
    logic tick;
    logic sync;
    logic bc_prev;
  } pmc_state_t;

  function automatic logic [2:0] pmc_popcnt(logic [3:0] v);
    return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : pmc_popcnt

  function automatic logic [31:0] pmc_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : pmc_merge

endpackage : pmc_pkg

//--- hw/pmc_sync.sv
`timescale 1ns/1ns
module pmc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pmc_sync_st_t;

  pmc_sync_st_t s_reg;
  pmc_sync_st_t s_next;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pmc_sync WIDTH must be at least 1");
  end

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb
  begin
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule : pmc_sync

//--- hw/pmc_top.sv
`timescale 1ns/1ns
module pmc_top #(
  parameter int unsigned SYNC_TICKS = pmc_pkg::SYNC_TICKS
) (
  input wire logic clk,
  input wire logic srst,
  input wire pmc_pkg::pmc_axi_req_t axi_req,
  output pmc_pkg::pmc_axi_rsp_t axi_rsp,
  input wire logic [1:0] rd_issue,
  input wire logic [1:0][3:0] rd_outstanding,
  input wire logic mem_access_evt,
  input wire logic [3:0] cache_rd_req,
  input wire logic [3:0] cache_rd_hit,
  input wire logic board_clk_16m,
  output logic ts_tick,
  output logic ts_sync
);

  localparam logic [7:0] SYNC_LAST = 8'(SYNC_TICKS - 1);

  if (SYNC_TICKS < 2 || SYNC_TICKS > 256)
  begin : g_bad_ticks
    $error("SYNC_TICKS must lie between 2 and 256");
  end

  pmc_pkg::pmc_state_t s_reg;
  pmc_pkg::pmc_state_t s_next;

  logic bc_q;
  logic wr_go;
  logic [2:0] wr_idx;
  logic wr_ok;
  logic [63:0] cur_val;
  logic commit_en;
  logic [63:0] commit_val;
  logic [2:0] rd_idx;
  logic rd_ok;
  logic [63:0] rd_val;
  logic [3:0] hit_vec;

  function automatic logic [63:0] reg_val(pmc_pkg::pmc_state_t st, logic [2:0] idx);
    logic [63:0] v;
    v = 64'h0;
    if (idx == pmc_pkg::REG_LAT0)
    begin
      v = {st.lat_cnt[0], st.lat_sum[0]};
    end
    else if (idx == pmc_pkg::REG_LAT1)
    begin
      v = {st.lat_cnt[1], st.lat_sum[1]};
    end
    else if (idx == pmc_pkg::REG_MEM)
    begin
      v = {32'h0, st.mem};
    end
    else if (idx == pmc_pkg::REG_HIT)
    begin
      v = {st.hit, st.rdc};
    end
    else if (idx == pmc_pkg::REG_TS)
    begin
      v = {16'h0, st.ts};
    end
    return v;
  endfunction : reg_val

  pmc_sync #(
    .WIDTH(1)
  ) u_board_sync (
    .clk(clk),
    .srst(srst),
    .d(board_clk_16m),
    .q(bc_q)
  );

  // Each 64-bit register is two words; the high word of a write commits both halves at once.
  assign wr_go = s_reg.aw_full && s_reg.w_full && !s_reg.rsp.bvalid;
  assign wr_idx = s_reg.awaddr[5:3];
  assign wr_ok = (s_reg.awaddr[7:6] == 2'h0) && (wr_idx < pmc_pkg::REG_CNT);
  assign cur_val = reg_val(s_reg, wr_idx);
  assign commit_en = wr_go && wr_ok && s_reg.awaddr[2];
  assign commit_val = {pmc_pkg::pmc_merge(cur_val[63:32], s_reg.wdata, s_reg.wstrb), s_reg.stage};
  assign rd_idx = axi_req.araddr[5:3];
  assign rd_ok = (axi_req.araddr[7:6] == 2'h0) && (rd_idx < pmc_pkg::REG_CNT);
  assign rd_val = reg_val(s_reg, rd_idx);
  assign hit_vec = cache_rd_req & cache_rd_hit;

  always_comb
  begin
    s_next = s_reg;
    s_next.bc_prev = bc_q;
    s_next.tick = bc_q && !s_reg.bc_prev;
    s_next.sync = 1'b0;

    // Fields are added separately so a full count never carries into the latency total.
    for (int p = 0; p < 2; p++)
    begin
      s_next.lat_cnt[p] = s_reg.lat_cnt[p] + pmc_pkg::pmc_cnt_t'(rd_issue[p]);
      s_next.lat_sum[p] = s_reg.lat_sum[p] + pmc_pkg::pmc_lat_t'(rd_outstanding[p]);
    end
    s_next.mem = s_reg.mem + pmc_pkg::pmc_w32_t'(mem_access_evt);
    s_next.hit = s_reg.hit + pmc_pkg::pmc_w32_t'(pmc_pkg::pmc_popcnt(hit_vec));
    s_next.rdc = s_reg.rdc + pmc_pkg::pmc_w32_t'(pmc_pkg::pmc_popcnt(cache_rd_req));

    if (s_reg.tick)
    begin
      s_next.pre = s_reg.pre + 4'h1;
      s_next.sync = (s_reg.tcnt == SYNC_LAST);
      s_next.tcnt = (s_reg.tcnt == SYNC_LAST) ? 8'h0 : s_reg.tcnt + 8'h1;
      if (s_reg.pre == pmc_pkg::PRE_MAX)
      begin
        s_next.ts = s_reg.ts + 48'h1;
      end
    end

    if (s_reg.rsp.awready && axi_req.awvalid)
    begin
      s_next.aw_full = 1'b1;
      s_next.awaddr = axi_req.awaddr;
    end
    if (s_reg.rsp.wready && axi_req.wvalid)
    begin
      s_next.w_full = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end

    // A software write overrides the increment computed above for the same cycle.
    if (commit_en)
    begin
      if (wr_idx == pmc_pkg::REG_LAT0)
      begin
        s_next.lat_cnt[0] = commit_val[63:36];
        s_next.lat_sum[0] = commit_val[35:0];
      end
      else if (wr_idx == pmc_pkg::REG_LAT1)
      begin
        s_next.lat_cnt[1] = commit_val[63:36];
        s_next.lat_sum[1] = commit_val[35:0];
      end
      else if (wr_idx == pmc_pkg::REG_MEM)
      begin
        s_next.mem = commit_val[31:0];
      end
      else if (wr_idx == pmc_pkg::REG_HIT)
      begin
        s_next.hit = commit_val[63:32];
        s_next.rdc = commit_val[31:0];
      end
      else if (wr_idx == pmc_pkg::REG_TS)
      begin
        s_next.ts = commit_val[47:0];
      end
    end
    if (wr_go && wr_ok && !s_reg.awaddr[2])
    begin
      s_next.stage = pmc_pkg::pmc_merge(cur_val[31:0], s_reg.wdata, s_reg.wstrb);
    end

    if (wr_go)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.rsp.bvalid = 1'b1;
      s_next.rsp.bresp = wr_ok ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
    end
    else if (s_reg.rsp.bvalid && axi_req.bready)
    begin
      s_next.rsp.bvalid = 1'b0;
    end

    // A low-word read freezes the high word, so the pair is one coherent sample.
    if (s_reg.rsp.arready && axi_req.arvalid)
    begin
      s_next.rsp.rvalid = 1'b1;
      if (!rd_ok)
      begin
        s_next.rsp.rdata = 32'h0;
        s_next.rsp.rresp = pmc_pkg::RESP_SLVERR;
      end
      else if (!axi_req.araddr[2])
      begin
        s_next.rsp.rdata = rd_val[31:0];
        s_next.snap = rd_val[63:32];
        s_next.rsp.rresp = pmc_pkg::RESP_OKAY;
      end
      else
      begin
        s_next.rsp.rdata = s_reg.snap;
        s_next.rsp.rresp = pmc_pkg::RESP_OKAY;
      end
    end
    else if (s_reg.rsp.rvalid && axi_req.rready)
    begin
      s_next.rsp.rvalid = 1'b0;
    end

    s_next.rsp.awready = !s_next.aw_full && !s_next.rsp.bvalid;
    s_next.rsp.wready = !s_next.w_full && !s_next.rsp.bvalid;
    s_next.rsp.arready = !s_next.rsp.rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign axi_rsp = s_reg.rsp;
  assign ts_tick = s_reg.tick;
  assign ts_sync = s_reg.sync;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_lat_sum: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_LAT0)
    |-> s_reg.lat_sum[0] == $past(s_reg.lat_sum[0]) + pmc_pkg::pmc_lat_t'($past(rd_outstanding[0]))
  ) else $error("latency total of processor 0 did not add outstanding reads");

  chk_lat1_count: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_LAT1)
    |-> s_reg.lat_cnt[1] == $past(s_reg.lat_cnt[1]) + pmc_pkg::pmc_cnt_t'($past(rd_issue[1]))
  ) else $error("read count of processor 1 is wrong");

  chk_lat0_count: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_LAT0)
    |-> s_reg.lat_cnt[0] == $past(s_reg.lat_cnt[0]) + pmc_pkg::pmc_cnt_t'($past(rd_issue[0]))
  ) else $error("read count of processor 0 is wrong");

  chk_count_wrap: assert property (
    !$past(srst) && $past(s_reg.lat_cnt[0]) == '1 && $past(rd_issue[0]) && !$past(commit_en)
    |-> s_reg.lat_cnt[0] == '0
    && s_reg.lat_sum[0] == $past(s_reg.lat_sum[0]) + pmc_pkg::pmc_lat_t'($past(rd_outstanding[0]))
  ) else $error("read count wrap disturbed its neighbour");

  chk_mem_count: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_MEM)
    |-> s_reg.mem == $past(s_reg.mem) + pmc_pkg::pmc_w32_t'($past(mem_access_evt))
  ) else $error("memory access count is wrong");

  chk_hit_count: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_HIT)
    |-> s_reg.hit == $past(s_reg.hit) + pmc_pkg::pmc_w32_t'(pmc_pkg::pmc_popcnt($past(hit_vec)))
  ) else $error("cache hit count is wrong");

  chk_read_count: assert property (
    !$past(srst) && !$past(commit_en && wr_idx == pmc_pkg::REG_HIT)
    |-> s_reg.rdc == $past(s_reg.rdc)
    + pmc_pkg::pmc_w32_t'(pmc_pkg::pmc_popcnt($past(cache_rd_req)))
  ) else $error("cache read count is wrong");

  chk_hit_load: assert property (
    commit_en && wr_idx == pmc_pkg::REG_HIT |=> {s_reg.hit, s_reg.rdc} == $past(commit_val)
  ) else $error("hit rate write did not load both fields");

  chk_lat_load: assert property (
    commit_en && wr_idx == pmc_pkg::REG_LAT1
    |=> {s_reg.lat_cnt[1], s_reg.lat_sum[1]} == $past(commit_val)
  ) else $error("latency write lost to an increment");

  chk_read_pair: assert property (
    s_reg.rsp.arready && axi_req.arvalid && rd_ok && !axi_req.araddr[2]
    |=> s_reg.rsp.rvalid && s_reg.rsp.rdata == $past(rd_val[31:0])
    && s_reg.snap == $past(rd_val[63:32])
  ) else $error("low word read did not capture a coherent pair");

  chk_tick_edge: assert property (
    !$past(srst) && !$past(srst, 2) |-> ts_tick == ($past(bc_q) && !$past(bc_q, 2))
  ) else $error("tick does not follow the board clock edge");

  chk_sync_pulse: assert property (
    ts_sync |-> $past(ts_tick) && $past(s_reg.tcnt) == SYNC_LAST && s_reg.tcnt == 8'h0
  ) else $error("sync pulse off its tick count");

  chk_ts_step: assert property (
    s_reg.tick && s_reg.pre == pmc_pkg::PRE_MAX && !(commit_en && wr_idx == pmc_pkg::REG_TS)
    |=> s_reg.ts == $past(s_reg.ts) + 48'h1 && s_reg.pre == 4'h0
  ) else $error("timestamp did not advance at prescaler maximum");

  chk_write_resp: assert property (
    wr_go |=> s_reg.rsp.bvalid && !s_reg.rsp.awready && !s_reg.rsp.wready
  ) else $error("write response missing");

  cov_write: cover property (commit_en ##1 s_reg.rsp.bvalid && axi_req.bready);
  cov_read: cover property (s_reg.rsp.rvalid && axi_req.rready);
  cov_sync: cover property (ts_sync);
  cov_ts: cover property (s_reg.tick && s_reg.pre == pmc_pkg::PRE_MAX);

endmodule : pmc_top

//--- tb/pmc_far_model.sv
`timescale 1ns/1ns
module pmc_far_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  output logic [1:0] rd_issue,
  output logic [1:0][3:0] rd_outstanding,
  output logic mem_access_evt,
  output logic [3:0] cache_rd_req,
  output logic [3:0] cache_rd_hit,
  output logic board_clk_16m
);
  logic [7:0] k;

  // The board clock runs free with no phase tie to clk, so tick gaps mix 7 and 8 cycles.
  initial
  begin
    k = 8'h00;
    rd_issue = 2'h0;
    rd_outstanding = '0;
    mem_access_evt = 1'b0;
    cache_rd_req = 4'h0;
    cache_rd_hit = 4'h0;
    board_clk_16m = 1'b0;
    #3;
    forever #31 board_clk_16m = ~board_clk_16m;
  end

  always @(posedge clk)
  begin
    k <= (srst || !en) ? 8'h00 : k + 8'h01;
    rd_issue <= en ? k[1:0] : 2'h0;
    rd_outstanding[0] <= en ? {1'b0, k[2:0]} : 4'h0;
    // Never zero while enabled, so a register write always meets a live increment.
    rd_outstanding[1] <= en ? (k[0] ? 4'ha : 4'h1) : 4'h0;
    mem_access_evt <= en & (k[0] ^ k[2]);
    cache_rd_req <= en ? k[3:0] : 4'h0;
    cache_rd_hit <= k[4:1];
  end
endmodule : pmc_far_model

//--- tb/tb_pmc_top.sv
`timescale 1ns/1ns
module tb_pmc_top;
  localparam int unsigned TICKS = 4;
  logic clk;
  logic srst;
  logic en;
  pmc_pkg::pmc_axi_req_t req;
  pmc_pkg::pmc_axi_rsp_t rsp;
  logic [1:0] rd_issue;
  logic [1:0][3:0] rd_out;
  logic mem_evt;
  logic [3:0] c_req;
  logic [3:0] c_hit;
  logic bclk;
  logic ts_tick;
  logic ts_sync;
  int miscompares;
  int n_checks;
  logic [63:0] s_iss [2];
  logic [63:0] s_out [2];
  logic [63:0] s_mem;
  logic [63:0] s_hit;
  logic [63:0] s_req;
  logic [63:0] b_iss;
  logic [63:0] b_out;
  logic [63:0] wv [4];
  logic [63:0] got;
  logic [31:0] w;
  logic [31:0] t0;
  logic [1:0] resp;
  pmc_pkg::pmc_cnt_t ec;
  pmc_pkg::pmc_lat_t el;
  int n;
  int gap;

  pmc_top #(.SYNC_TICKS(TICKS)) i_dut (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp),
    .rd_issue(rd_issue), .rd_outstanding(rd_out), .mem_access_evt(mem_evt),
    .cache_rd_req(c_req), .cache_rd_hit(c_hit), .board_clk_16m(bclk),
    .ts_tick(ts_tick), .ts_sync(ts_sync));

  pmc_far_model i_far (.clk(clk), .srst(srst), .en(en), .rd_issue(rd_issue),
    .rd_outstanding(rd_out), .mem_access_evt(mem_evt), .cache_rd_req(c_req),
    .cache_rd_hit(c_hit), .board_clk_16m(bclk));

  always #4 clk = ~clk;

  // Expected sums follow the stimulus, so they never lean on what the design reports.
  always @(posedge clk)
  begin
    if (!srst)
    begin
      for (int p = 0; p < 2; p++)
      begin
        s_iss[p] += {63'h0, rd_issue[p]};
        s_out[p] += {60'h0, rd_out[p]};
      end
      s_mem += {63'h0, mem_evt};
      s_hit += 64'($countones(c_req & c_hit));
      s_req += 64'($countones(c_req));
    end
  end

  // The edge that raises bvalid is the commit edge; its increment is lost to the write.
  always @(negedge clk)
  begin
    if (rsp.bvalid === 1'b1)
    begin
      b_iss = s_iss[1];
      b_out = s_out[1];
    end
  end

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    logic [1:0] r;
    axi_wr(a, v[31:0], r);
    chk_resp("write resp low", pmc_pkg::RESP_OKAY, r);
    axi_wr(a + 8'h04, v[63:32], r);
    chk_resp("write resp high", pmc_pkg::RESP_OKAY, r);
  endtask : wr64

  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    logic [1:0] r;
    axi_rd(a, v[31:0], r);
    chk_resp("read resp low", pmc_pkg::RESP_OKAY, r);
    axi_rd(a + 8'h04, v[63:32], r);
    chk_resp("read resp high", pmc_pkg::RESP_OKAY, r);
  endtask : rd64

  task automatic wait_ticks(input int k);
    int c;
    c = 0;
    for (int t = 0; t < 4000 && c < k; t++)
    begin
      @(posedge clk);
      if (ts_tick === 1'b1)
        c++;
    end
    chk_val("ticks seen", 64'(k), 64'(c));
  endtask : wait_ticks

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    en = 1'b0;
    req = '0;
    wv[0] = 64'hffff_ffff_ffff_ff00;
    wv[1] = 64'h0000_0010_0000_0000;
    wv[2] = 64'h1234_5678_ffff_fff0;
    wv[3] = 64'h0000_0005_ffff_ff80;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd64(8'(8 * i), got);
      chk_val("reset value", 64'h0, got);
      wr64(8'(8 * i), wv[i]);
      rd64(8'(8 * i), got);
      chk_val("readback", (i == 2) ? {32'h0, wv[i][31:0]} : wv[i], got);
    end
    @(negedge clk);
    s_iss = '{64'h0, 64'h0};
    s_out = '{64'h0, 64'h0};
    s_mem = 64'h0;
    s_hit = 64'h0;
    s_req = 64'h0;
    @(posedge clk);
    en <= 1'b1;
    repeat (100) @(posedge clk);
    wr64(8'h08, wv[1]);
    repeat (100) @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 2; p++)
    begin
      ec = wv[p][63:36] + pmc_pkg::pmc_cnt_t'(s_iss[p] - ((p == 1) ? b_iss : 64'h0));
      el = wv[p][35:0] + pmc_pkg::pmc_lat_t'(s_out[p] - ((p == 1) ? b_out : 64'h0));
      rd64(8'(8 * p), got);
      chk_val("latency reg", {ec, el}, got);
    end
    rd64(8'h10, got);
    chk_val("mem count", {32'h0, wv[2][31:0] + s_mem[31:0]}, got);
    rd64(8'h18, got);
    chk_val("hit rate", {wv[3][63:32] + s_hit[31:0], wv[3][31:0] + s_req[31:0]}, got);
    axi_rd(8'h28, w, resp);
    chk_resp("unmapped read resp", pmc_pkg::RESP_SLVERR, resp);
    chk_val("unmapped read data", 64'h0, {32'h0, w});
    axi_wr(8'h2c, 32'hffff_ffff, resp);
    chk_resp("unmapped write resp", pmc_pkg::RESP_SLVERR, resp);
    // Each read starts at the same offset after a tick, so 32 ticks give exactly two steps.
    wait_ticks(1);
    axi_rd(8'h20, t0, resp);
    wait_ticks(32);
    axi_rd(8'h20, w, resp);
    chk_val("timestamp step", {32'h0, t0 + 32'h2}, {32'h0, w});
    for (int t = 0; t < 2000 && ts_sync !== 1'b1; t++)
      @(posedge clk);
    n = 0;
    gap = 0;
    for (int t = 0; t < 2000; t++)
    begin
      @(posedge clk);
      if (ts_tick === 1'b1)
      begin
        if (n > 0)
          chk_val("tick gap", 64'h1, {63'h0, gap == 7 || gap == 8});
        n++;
        gap = 0;
      end
      gap++;
      if (ts_sync === 1'b1)
        break;
    end
    chk_val("ticks per sync", 64'(TICKS), 64'(n));
    report_and_stop();
  end
endmodule : tb_pmc_top
